// File: rtl/dpc_config_bank.v
// configuration register bank of the dual-pll clock generator
//
// What this block does
// - nine-bit half-ramp count, 0x2B plus 0x2C bit7
// - seven-bit ramp update divisor in 0x2C low
// - eight-bit ramp increment fills register 0x2A
// - alt_map_select_pin pll one ratio, 0x30 low six
// - alt_map_select_pin pll two ratio, 0x33 low six
// - alt_map_select_pin fraction and modulus from 0x34-0x36
// - nominal fraction and modulus from 0x19-0x1B
// - channel registers: vco 7:5, output 4:0
// - 0x3A: ch3, ch2 power, two formats
// - second byte is address, then auto-increment
`timescale 1ns/100ps
`include "dpc_defines.vh"
module dpc_config_bank (
    input wire clk_sys,
    input wire rst,
    input wire byteValid,
    input wire [7:0] byteData,
    input wire frameStart,
    input wire frameStop,
    input wire alt_map_select_pin,
    output wire addrAck,
    output reg [5:0] pll_one_feedback_ratio,
    output reg [5:0] pll_two_feedback_ratio,
    output reg [11:0] sdm_numerator,
    output reg [11:0] sdm_denominator,
    output reg [2:0] ch0_vco_divide,
    output reg [4:0] ch0_out_divide,
    output reg [2:0] ch1_vco_divide,
    output reg [4:0] ch1_out_divide,
    output reg [2:0] ch2_vco_divide,
    output reg [4:0] ch2_out_divide,
    output reg [2:0] ch3_vco_divide,
    output reg [4:0] ch3_out_divide,
    output reg [7:0] ramp_increment,
    output reg [8:0] half_ramp_step_count,
    output reg [6:0] ramp_update_divisor,
    output reg modulator_power_off,
    output reg bleed_enable,
    output reg ch0_power_off,
    output reg ch1_power_off,
    output reg ch2_power_off,
    output reg ch3_power_off,
    output reg [2:0] pll_one_output_style,
    output reg [2:0] pll_two_output_style,
    output reg ref_buffer_power_off,
    output reg pll_one_power_off,
    output reg pll_two_power_off,
    output reg ref_divide_two,
    output reg reacquire_bit,
    output reg pll_one_outputs_align,
    output reg pll_two_outputs_align,
    output reg serial_control_enable_bit,
    output reg marginActive
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    // two flops: the alt_map_select_pin pin is not timed to clk_sys
    reg marginMeta_reg;
    reg marginSync_reg;
    always @(posedge clk_sys) begin
        if (rst) begin
            marginMeta_reg <= 1'b0;
            marginSync_reg <= 1'b0;
        end else begin
            marginMeta_reg <= alt_map_select_pin;
            marginSync_reg <= marginMeta_reg;
        end
    end

    // ------------------------------------------------------------
    // write sequencer
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_ADDR = 2'b01;
    localparam [1:0] ST_DATA = 2'b10;
    localparam [1:0] ST_HALT = 2'b11;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [7:0] addr_reg;
    reg [7:0] addr_next;
    reg wrStrobe;

    // ------------------------------------------------------------
    // frame edges
    // ------------------------------------------------------------
    // a start or stop wins over a byte in the same cycle: that byte is dropped,
    // so the serial engine may report both without ordering them
    wire frameEdge = frameStart || frameStop;

    // the address byte is acknowledged only when it names a register
    function addrKnown;
        input [7:0] a;
        begin
            case (a)
                `DPC_ADDR_BLEED, `DPC_ADDR_FB_ONE, `DPC_ADDR_NUM_HI,
                `DPC_ADDR_NUM_LO_DEN_HI, `DPC_ADDR_DEN_LO, `DPC_ADDR_FB_TWO,
                `DPC_ADDR_MOD_PWR, `DPC_ADDR_REACQ, `DPC_ADDR_CH0, `DPC_ADDR_CH1,
                `DPC_ADDR_SYNC_ONE, `DPC_ADDR_CH2, `DPC_ADDR_CH3,
                `DPC_ADDR_SYNC_TWO, `DPC_ADDR_STEP, `DPC_ADDR_CNT_HI,
                `DPC_ADDR_CNT_LO_DIV, `DPC_ADDR_M_FB_ONE, `DPC_ADDR_M_CH0,
                `DPC_ADDR_M_CH1, `DPC_ADDR_M_FB_TWO, `DPC_ADDR_M_NUM_HI,
                `DPC_ADDR_M_NUM_LO_DEN_HI, `DPC_ADDR_M_DEN_LO, `DPC_ADDR_M_CH3,
                `DPC_ADDR_M_CH2, `DPC_ADDR_FMT_PWR, `DPC_ADDR_REF_PWR,
                `DPC_ADDR_GLOBAL, `DPC_ADDR_SER_EN: addrKnown = 1'b1;
                default: addrKnown = 1'b0;
            endcase
        end
    endfunction

    assign addrAck = (state_reg == ST_ADDR) &&
        byteValid &&
        !frameEdge &&
        addrKnown(byteData);

    always @* begin
        state_next = state_reg;
        addr_next = addr_reg;
        wrStrobe = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (byteValid) begin
                    state_next = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (byteValid) begin
                    if (addrKnown(byteData)) begin
                        addr_next = byteData;
                        state_next = ST_DATA;
                    end else begin
                        // refused address: the rest of the frame is ignored
                        state_next = ST_HALT;
                    end
                end
            end
            ST_DATA: begin
                if (byteValid) begin
                    wrStrobe = 1'b1;
                    // wraps past 8'hff; unmapped addresses in the run write nothing
                    addr_next = addr_reg + 8'h01;
                end
            end
            ST_HALT: begin
                // only a start or stop leaves this state
                state_next = ST_HALT;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // a stop or repeated start abandons the frame in any state
        if (frameEdge) begin
            state_next = ST_IDLE;
            wrStrobe = 1'b0;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            addr_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
        end
    end

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    localparam NREG = 30;
    localparam [NREG*8-1:0] ADDR_LIST = {
        `DPC_ADDR_BLEED, `DPC_ADDR_FB_ONE, `DPC_ADDR_NUM_HI,
        `DPC_ADDR_NUM_LO_DEN_HI, `DPC_ADDR_DEN_LO, `DPC_ADDR_FB_TWO,
        `DPC_ADDR_MOD_PWR, `DPC_ADDR_REACQ, `DPC_ADDR_CH0, `DPC_ADDR_CH1,
        `DPC_ADDR_SYNC_ONE, `DPC_ADDR_CH2, `DPC_ADDR_CH3, `DPC_ADDR_SYNC_TWO,
        `DPC_ADDR_STEP, `DPC_ADDR_CNT_HI, `DPC_ADDR_CNT_LO_DIV,
        `DPC_ADDR_M_FB_ONE, `DPC_ADDR_M_CH0, `DPC_ADDR_M_CH1,
        `DPC_ADDR_M_FB_TWO, `DPC_ADDR_M_NUM_HI, `DPC_ADDR_M_NUM_LO_DEN_HI,
        `DPC_ADDR_M_DEN_LO, `DPC_ADDR_M_CH3, `DPC_ADDR_M_CH2,
        `DPC_ADDR_FMT_PWR, `DPC_ADDR_REF_PWR, `DPC_ADDR_GLOBAL,
        `DPC_ADDR_SER_EN};
    // index 0 is the last entry of the list above
    localparam R_SER_EN = 0;
    localparam R_GLOBAL = 1;
    localparam R_REF_PWR = 2;
    localparam R_FMT_PWR = 3;
    localparam R_M_CH2 = 4;
    localparam R_M_CH3 = 5;
    localparam R_M_DEN_LO = 6;
    localparam R_M_NUM_LO = 7;
    localparam R_M_NUM_HI = 8;
    localparam R_M_FB_TWO = 9;
    localparam R_M_CH1 = 10;
    localparam R_M_CH0 = 11;
    localparam R_M_FB_ONE = 12;
    localparam R_CNT_LO = 13;
    localparam R_CNT_HI = 14;
    localparam R_STEP = 15;
    localparam R_SYNC_TWO = 16;
    localparam R_CH3 = 17;
    localparam R_CH2 = 18;
    localparam R_SYNC_ONE = 19;
    localparam R_CH1 = 20;
    localparam R_CH0 = 21;
    localparam R_REACQ = 22;
    localparam R_MOD_PWR = 23;
    localparam R_FB_TWO = 24;
    localparam R_DEN_LO = 25;
    localparam R_NUM_LO = 26;
    localparam R_NUM_HI = 27;
    localparam R_FB_ONE = 28;
    localparam R_BLEED = 29;

    // write-only: nothing drives a read path, values hold until rewritten
    wire [NREG*8-1:0] regFlat;
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
            dpc_byte_reg #(
                .ADDR(ADDR_LIST[gi*8 +: 8])
            ) u_reg (
                .clk_sys(clk_sys),
                .rst(rst),
                .wrStrobe(wrStrobe),
                .wrAddr(addr_reg),
                .wrData(byteData),
                .value(regFlat[gi*8 +: 8])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // field decode and map selection
    // ------------------------------------------------------------
    wire [7:0] rFbOne = regFlat[R_FB_ONE*8 +: 8];
    wire [7:0] rFbTwo = regFlat[R_FB_TWO*8 +: 8];
    wire [7:0] rNumHi = regFlat[R_NUM_HI*8 +: 8];
    wire [7:0] rNumLo = regFlat[R_NUM_LO*8 +: 8];
    wire [7:0] rDenLo = regFlat[R_DEN_LO*8 +: 8];
    wire [7:0] rMFbOne = regFlat[R_M_FB_ONE*8 +: 8];
    wire [7:0] rMFbTwo = regFlat[R_M_FB_TWO*8 +: 8];
    wire [7:0] rMNumHi = regFlat[R_M_NUM_HI*8 +: 8];
    wire [7:0] rMNumLo = regFlat[R_M_NUM_LO*8 +: 8];
    wire [7:0] rMDenLo = regFlat[R_M_DEN_LO*8 +: 8];
    wire [7:0] rCnt = regFlat[R_CNT_LO*8 +: 8];
    wire [7:0] rFmt = regFlat[R_FMT_PWR*8 +: 8];
    wire [7:0] rGlob = regFlat[R_GLOBAL*8 +: 8];
    wire [7:0] rBleed = regFlat[R_BLEED*8 +: 8];
    // the alt_map_select_pin pin swaps whole maps; each channel picks its byte
    wire [7:0] ch0Sel = marginSync_reg ? regFlat[R_M_CH0*8 +: 8] : regFlat[R_CH0*8 +: 8];
    wire [7:0] ch1Sel = marginSync_reg ? regFlat[R_M_CH1*8 +: 8] : regFlat[R_CH1*8 +: 8];
    wire [7:0] ch2Sel = marginSync_reg ? regFlat[R_M_CH2*8 +: 8] : regFlat[R_CH2*8 +: 8];
    wire [7:0] ch3Sel = marginSync_reg ? regFlat[R_M_CH3*8 +: 8] : regFlat[R_CH3*8 +: 8];

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    // outputs come from flops so a bus write never glitches a divider input
    always @(posedge clk_sys) begin
        if (rst) begin
            pll_one_feedback_ratio <= 6'h00;
            pll_two_feedback_ratio <= 6'h00;
            sdm_numerator <= 12'h000;
            sdm_denominator <= 12'h000;
            ch0_vco_divide <= 3'h0;
            ch0_out_divide <= 5'h00;
            ch1_vco_divide <= 3'h0;
            ch1_out_divide <= 5'h00;
            ch2_vco_divide <= 3'h0;
            ch2_out_divide <= 5'h00;
            ch3_vco_divide <= 3'h0;
            ch3_out_divide <= 5'h00;
            ramp_increment <= 8'h00;
            half_ramp_step_count <= 9'h000;
            ramp_update_divisor <= 7'h00;
            modulator_power_off <= 1'b0;
            bleed_enable <= 1'b0;
            ch0_power_off <= 1'b0;
            ch1_power_off <= 1'b0;
            ch2_power_off <= 1'b0;
            ch3_power_off <= 1'b0;
            pll_one_output_style <= 3'h0;
            pll_two_output_style <= 3'h0;
            ref_buffer_power_off <= 1'b0;
            pll_one_power_off <= 1'b0;
            pll_two_power_off <= 1'b0;
            ref_divide_two <= 1'b0;
            reacquire_bit <= 1'b0;
            pll_one_outputs_align <= 1'b0;
            pll_two_outputs_align <= 1'b0;
            serial_control_enable_bit <= 1'b0;
            marginActive <= 1'b0;
        end else begin
            marginActive <= marginSync_reg;
            if (marginSync_reg) begin
                pll_one_feedback_ratio <= rMFbOne[`DPC_FB_MSB:0];
                pll_two_feedback_ratio <= rMFbTwo[`DPC_FB_MSB:0];
                sdm_numerator <= {rMNumHi, rMNumLo[7:4]};
                sdm_denominator <= {rMNumLo[3:0], rMDenLo};
            end else begin
                pll_one_feedback_ratio <= rFbOne[`DPC_FB_MSB:0];
                pll_two_feedback_ratio <= rFbTwo[`DPC_FB_MSB:0];
                sdm_numerator <= {rNumHi, rNumLo[7:4]};
                sdm_denominator <= {rNumLo[3:0], rDenLo};
            end
            ch0_vco_divide <= ch0Sel[`DPC_VCO_MSB:`DPC_VCO_LSB];
            ch0_out_divide <= ch0Sel[`DPC_OUT_MSB:`DPC_OUT_LSB];
            ch1_vco_divide <= ch1Sel[`DPC_VCO_MSB:`DPC_VCO_LSB];
            ch1_out_divide <= ch1Sel[`DPC_OUT_MSB:`DPC_OUT_LSB];
            ch2_vco_divide <= ch2Sel[`DPC_VCO_MSB:`DPC_VCO_LSB];
            ch2_out_divide <= ch2Sel[`DPC_OUT_MSB:`DPC_OUT_LSB];
            ch3_vco_divide <= ch3Sel[`DPC_VCO_MSB:`DPC_VCO_LSB];
            ch3_out_divide <= ch3Sel[`DPC_OUT_MSB:`DPC_OUT_LSB];
            // spread values only take effect in the modulator on an enable toggle
            ramp_increment <= regFlat[R_STEP*8 +: 8];
            half_ramp_step_count <= {regFlat[R_CNT_HI*8 +: 8], rCnt[`DPC_CNT_LSB_BIT]};
            ramp_update_divisor <= rCnt[`DPC_DIVISOR_MSB:0];
            modulator_power_off <= regFlat[R_MOD_PWR*8 + `DPC_MOD_OFF_BIT];
            bleed_enable <= rBleed[`DPC_BLEED_BIT];
            ch0_power_off <= rBleed[0];
            ch1_power_off <= rBleed[`DPC_CH1_OFF_BIT];
            ch3_power_off <= rFmt[`DPC_CH3_OFF_BIT];
            ch2_power_off <= rFmt[`DPC_CH2_OFF_BIT];
            pll_two_output_style <= rFmt[`DPC_FMT_TWO_MSB:`DPC_FMT_TWO_LSB];
            pll_one_output_style <= rFmt[`DPC_FMT_ONE_MSB:0];
            ref_buffer_power_off <= regFlat[R_REF_PWR*8];
            pll_one_power_off <= rGlob[`DPC_PLL_ONE_OFF_BIT];
            pll_two_power_off <= rGlob[`DPC_PLL_TWO_OFF_BIT];
            ref_divide_two <= rGlob[`DPC_REFDIV_BIT];
            reacquire_bit <= regFlat[R_REACQ*8];
            pll_one_outputs_align <= regFlat[R_SYNC_ONE*8];
            pll_two_outputs_align <= regFlat[R_SYNC_TWO*8];
            serial_control_enable_bit <= regFlat[R_SER_EN*8 + `DPC_SER_EN_BIT];
        end
    end
endmodule // dpc_config_bank

// File: rtl/dpc_defines.vh
// register offsets, field positions and reset values of the configuration bank
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH

`define DPC_ADDR_BLEED 8'h11
`define DPC_ADDR_FB_ONE 8'h18
`define DPC_ADDR_NUM_HI 8'h19
`define DPC_ADDR_NUM_LO_DEN_HI 8'h1a
`define DPC_ADDR_DEN_LO 8'h1b
`define DPC_ADDR_FB_TWO 8'h1c
`define DPC_ADDR_MOD_PWR 8'h1d
`define DPC_ADDR_REACQ 8'h1f
`define DPC_ADDR_CH0 8'h22
`define DPC_ADDR_CH1 8'h23
`define DPC_ADDR_SYNC_ONE 8'h24
`define DPC_ADDR_CH2 8'h25
`define DPC_ADDR_CH3 8'h26
`define DPC_ADDR_SYNC_TWO 8'h27
`define DPC_ADDR_STEP 8'h2a
`define DPC_ADDR_CNT_HI 8'h2b
`define DPC_ADDR_CNT_LO_DIV 8'h2c
`define DPC_ADDR_M_FB_ONE 8'h30
`define DPC_ADDR_M_CH0 8'h31
`define DPC_ADDR_M_CH1 8'h32
`define DPC_ADDR_M_FB_TWO 8'h33
`define DPC_ADDR_M_NUM_HI 8'h34
`define DPC_ADDR_M_NUM_LO_DEN_HI 8'h35
`define DPC_ADDR_M_DEN_LO 8'h36
`define DPC_ADDR_M_CH3 8'h37
`define DPC_ADDR_M_CH2 8'h38
`define DPC_ADDR_FMT_PWR 8'h3a
`define DPC_ADDR_REF_PWR 8'h3b
`define DPC_ADDR_GLOBAL 8'h3d
`define DPC_ADDR_SER_EN 8'h40

// field positions
`define DPC_VCO_MSB 7
`define DPC_VCO_LSB 5
`define DPC_OUT_MSB 4
`define DPC_OUT_LSB 0
`define DPC_FB_MSB 5
`define DPC_CNT_LSB_BIT 7
`define DPC_DIVISOR_MSB 6
`define DPC_CH3_OFF_BIT 7
`define DPC_CH2_OFF_BIT 6
`define DPC_FMT_TWO_MSB 5
`define DPC_FMT_TWO_LSB 3
`define DPC_FMT_ONE_MSB 2
`define DPC_PLL_ONE_OFF_BIT 3
`define DPC_PLL_TWO_OFF_BIT 2
`define DPC_REFDIV_BIT 1
`define DPC_MOD_OFF_BIT 4
`define DPC_BLEED_BIT 2
`define DPC_CH1_OFF_BIT 1
`define DPC_SER_EN_BIT 1

// reset value of every register; the power-up map is held elsewhere
`define DPC_RESET_BYTE 8'h00

`endif

// File: rtl/dpc_byte_reg.v
// one write-only byte register with address decode
`timescale 1ns/100ps
`include "dpc_defines.vh"
module dpc_byte_reg #(
    parameter [7:0] ADDR = 8'h00
) (
    input wire clk_sys,
    input wire rst,
    input wire wrStrobe,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData,
    output reg [7:0] value
);
    always @(posedge clk_sys) begin
        if (rst) begin
            value <= `DPC_RESET_BYTE;
        end else if (wrStrobe && wrAddr == ADDR) begin
            value <= wrData;
        end
    end
endmodule // dpc_byte_reg

// File: testbench/dpc_config_bank_checker.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/100ps
module dpc_config_bank_checker (
    input wire clk_sys,
    input wire rst,
    input wire byteValid,
    input wire [7:0] byteData,
    input wire frameStart,
    input wire frameStop,
    input wire alt_map_select_pin,
    input wire addrAck,
    input wire [5:0] pll_one_feedback_ratio,
    input wire [8:0] half_ramp_step_count,
    input wire [6:0] ramp_update_divisor,
    input wire [7:0] ramp_increment,
    input wire [2:0] pll_two_output_style,
    input wire marginActive
);
    reg [1:0] byteCnt;
    reg [1:0] cleanCnt;
    // byte count tells the address byte apart; clean count keeps $past clear of reset
    always @(posedge clk_sys) begin
        if (rst || frameStart || frameStop) byteCnt <= 2'h0;
        else if (byteValid && byteCnt != 2'h3) byteCnt <= byteCnt + 2'h1;
        if (rst) cleanCnt <= 2'h0;
        else if (cleanCnt != 2'h3) cleanCnt <= cleanCnt + 2'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_ack_second;
        addrAck |-> byteValid && byteCnt == 2'h1;
    endproperty
    property p_ack_framed;
        addrAck |-> !frameStart && !frameStop;
    endproperty
    property p_ack_map;
        byteValid && byteCnt == 2'h1 && !frameStart && !frameStop |-> addrAck == (byteData inside
            {8'h11, [8'h18:8'h1d], 8'h1f, [8'h22:8'h27], [8'h2a:8'h2c], [8'h30:8'h38], 8'h3a,
            8'h3b, 8'h3d, 8'h40});
    endproperty
    property p_reset_zero;
        $fell(rst) |-> {ramp_increment, half_ramp_step_count, pll_one_feedback_ratio} == 23'h0
            && !marginActive;
    endproperty
    property p_alt_map_select_pin_lag;
        cleanCnt == 2'h3 |-> marginActive == $past(alt_map_select_pin, 3);
    endproperty
    property p_fb_cause;
        cleanCnt == 2'h3 && $changed(pll_one_feedback_ratio) |-> $past(byteValid, 2)
            || $changed(marginActive) || $past(marginActive) != $past(marginActive, 2);
    endproperty
    property p_ramp_cause;
        cleanCnt == 2'h3 && $changed({half_ramp_step_count, ramp_update_divisor, ramp_increment})
            |-> $past(byteValid, 2);
    endproperty
    property p_style_cause;
        cleanCnt == 2'h3 && $changed(pll_two_output_style) |-> $past(byteValid, 2);
    endproperty
    a_ack_second: assert property (p_ack_second) else $error("address ack off the second byte");
    a_ack_framed: assert property (p_ack_framed) else $error("address ack with frame edge");
    a_ack_map: assert property (p_ack_map) else $error("address ack disagrees with map");
    a_reset_zero: assert property (p_reset_zero) else $error("outputs not cleared by reset");
    a_alt_map_select_pin_lag: assert property (p_alt_map_select_pin_lag) else $error("alt_map_select_pin select lag wrong");
    a_fb_cause: assert property (p_fb_cause) else $error("feedback ratio changed uncaused");
    a_ramp_cause: assert property (p_ramp_cause) else $error("ramp fields changed uncaused");
    a_style_cause: assert property (p_style_cause) else $error("output style changed uncaused");
    c_ack: cover property (addrAck);
    c_alt_map_select_pin: cover property ($rose(marginActive));
    c_ramp: cover property ($changed(half_ramp_step_count));
endmodule // dpc_config_bank_checker

bind dpc_config_bank dpc_config_bank_checker chk (.*);

// File: testbench/dpc_master_model.sv
// byte-level model of the serial bus master writing the bank
`timescale 1ns/100ps
module dpc_master_model #(
    parameter [7:0] DEV_BYTE = 8'h5a // arbitrary, content is ignored by the bank
) (
    input wire clk_sys,
    output reg frameStart,
    output reg frameStop,
    output reg byteValid,
    output reg [7:0] byteData
);
    reg spreadEnable;
    initial begin
        {frameStart, frameStop, byteValid, byteData} = 11'h0;
        spreadEnable = 1'b0;
    end
    // new spread settings reach the modulator only after the enable pin toggles
    task spread_toggle;
        begin
            @(negedge clk_sys);
            spreadEnable = ~spreadEnable;
            @(negedge clk_sys);
            spreadEnable = ~spreadEnable;
        end
    endtask
    // a released byte lane shows the inverse so no stale byte reads as fresh
    task put(input [7:0] b, input slow);
        begin
            if (slow) begin
                @(negedge clk_sys);
                {frameStart, byteValid, byteData} = {2'h0, ~byteData};
            end
            @(negedge clk_sys);
            {frameStart, frameStop, byteValid, byteData} = {3'h1, b};
        end
    endtask
    // device byte first, then the register address, then data
    task open(input slow);
        begin
            @(negedge clk_sys);
            {frameStart, byteValid, byteData} = {2'h2, ~byteData};
            put(DEV_BYTE, slow);
        end
    endtask
    task close;
        begin
            @(negedge clk_sys);
            {frameStop, byteValid, byteData} = {2'h2, ~byteData};
            @(negedge clk_sys);
            frameStop = 1'b0;
        end
    endtask
endmodule // dpc_master_model

// File: testbench/tb.sv
// self-checking bench for the configuration bank
`timescale 1ns/100ps
module tb;
    reg clk_sys, rst, alt_map_select_pin, mg, slow;
    wire frameStart, frameStop, byteValid, addrAck, marginActive;
    wire [7:0] byteData, ramp_increment;
    wire [5:0] pll_one_feedback_ratio, pll_two_feedback_ratio;
    wire [11:0] sdm_numerator, sdm_denominator;
    wire [2:0] ch0_vco_divide, ch1_vco_divide, ch2_vco_divide, ch3_vco_divide;
    wire [4:0] ch0_out_divide, ch1_out_divide, ch2_out_divide, ch3_out_divide;
    wire [8:0] half_ramp_step_count;
    wire [6:0] ramp_update_divisor;
    wire [2:0] pll_one_output_style, pll_two_output_style;
    wire modulator_power_off, bleed_enable, ch0_power_off, ch1_power_off, ch2_power_off;
    wire ch3_power_off, ref_buffer_power_off, pll_one_power_off, pll_two_power_off;
    wire ref_divide_two, reacquire_bit, pll_one_outputs_align, pll_two_outputs_align;
    wire serial_control_enable_bit;
    integer mismatches, tests_run, i, k;
    reg [7:0] sh [0:255];
    reg [7:0] dat [0:15];
    dpc_master_model m (.clk_sys(clk_sys), .frameStart(frameStart), .frameStop(frameStop),
        .byteValid(byteValid), .byteData(byteData));
    dpc_config_bank DUT (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    function mapped(input [7:0] a);
        mapped = a inside {8'h11, [8'h18:8'h1d], 8'h1f, [8'h22:8'h27], [8'h2a:8'h2c],
            [8'h30:8'h38], 8'h3a, 8'h3b, 8'h3d, 8'h40};
    endfunction
    function [7:0] r(input [7:0] nom, input [7:0] alt);
        r = mg ? sh[alt] : sh[nom];
    endfunction
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input integer n);
        reg [7:0] p;
        begin
            m.open(slow);
            m.put(a, slow);
            #5 chk(addrAck, mapped(a));
            p = a;
            for (k = 0; k < n; k = k + 1) begin
                m.put(dat[k], slow);
                if (mapped(a) && mapped(p)) sh[p] = dat[k];
                p = p + 8'h01;
            end
            m.close;
        end
    endtask
    task verify;
        begin
            repeat (4) @(negedge clk_sys);
            chk(pll_one_feedback_ratio, r(8'h18, 8'h30) & 8'h3f);
            chk(pll_two_feedback_ratio, r(8'h1c, 8'h33) & 8'h3f);
            chk({sdm_numerator, sdm_denominator}, {r(8'h19, 8'h34), r(8'h1a, 8'h35),
                r(8'h1b, 8'h36)});
            chk({ch0_vco_divide, ch0_out_divide}, r(8'h22, 8'h31));
            chk({ch1_vco_divide, ch1_out_divide}, r(8'h23, 8'h32));
            chk({ch2_vco_divide, ch2_out_divide}, r(8'h25, 8'h38));
            chk({ch3_vco_divide, ch3_out_divide}, r(8'h26, 8'h37));
            chk(ramp_increment, sh[8'h2a]);
            chk({half_ramp_step_count, ramp_update_divisor}, {sh[8'h2b], sh[8'h2c]});
            chk({ch3_power_off, ch2_power_off, pll_two_output_style, pll_one_output_style},
                sh[8'h3a]);
            chk({pll_one_power_off, pll_two_power_off, ref_divide_two}, sh[8'h3d][3:1]);
            chk({bleed_enable, ch1_power_off, ch0_power_off, modulator_power_off, reacquire_bit,
                pll_one_outputs_align, pll_two_outputs_align, ref_buffer_power_off,
                serial_control_enable_bit, marginActive}, {sh[8'h11][2:0], sh[8'h1d][4],
                sh[8'h1f][0], sh[8'h24][0], sh[8'h27][0], sh[8'h3b][0], sh[8'h40][1], mg});
        end
    endtask
    task print_verdict;
        begin
            $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
            if (mismatches == 0 && tests_run > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #(20 * 20000);
        mismatches = mismatches + 1;
        print_verdict;
    end
    initial begin
        {mismatches, tests_run, rst, alt_map_select_pin, mg, slow} = 68'h8;
        i = $urandom(32'h8963);
        for (i = 0; i < 256; i = i + 1) sh[i] = 8'h00;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        verify;
        // ramp fields from the handed-over walk, back to back
        {dat[0], dat[1], dat[2]} = 24'hf91689;
        wr(8'h2a, 3);
        m.spread_toggle;
        verify;
        // full map sweeps: all-ones first, then random; runs cross unmapped holes
        for (i = 0; i < 4; i = i + 1) begin
            for (k = 0; k < 16; k = k + 1) dat[k] = (i == 0) ? 8'hff : 8'($urandom);
            slow = i[0];
            wr(8'h11, 16);
            wr(8'h22, 6);
            wr(8'h2a, 3);
            wr(8'h30, 9);
            wr(8'h3a, 4);
            wr(8'h40, 1);
            m.spread_toggle;
            alt_map_select_pin = i[1];
            mg = i[1];
            verify;
        end
        // single rewrite keeps the rest; unmapped starts write nothing
        dat[0] = 8'($urandom);
        dat[1] = ~dat[0];
        wr(8'h2b, 1);
        wr(8'h3c, 2);
        wr(8'h20, 2);
        wr(8'hff, 2);
        verify;
        // reset in mid-run clears every register
        rst = 1'b1;
        alt_map_select_pin = 1'b0;
        mg = 1'b0;
        for (i = 0; i < 256; i = i + 1) sh[i] = 8'h00;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        verify;
        print_verdict;
    end
endmodule // tb
